// File: ea_pkg.sv
// shared types and constants for the effective address unit
// assumes one processor clock; register numbers are 4 bits: bank, number
`default_nettype none
package ea_pkg;
    localparam int ADDR_BITS = 32;
    localparam int EXT_BITS = 16;
    localparam int BRIEF_BITS = 8;

    localparam logic [2:0] MODE_DATA_DIRECT = 3'h0;
    localparam logic [2:0] MODE_ADDR_DIRECT = 3'h1;
    localparam logic [2:0] MODE_INDIRECT = 3'h2;
    localparam logic [2:0] MODE_POSTINC = 3'h3;
    localparam logic [2:0] MODE_PREDEC = 3'h4;
    localparam logic [2:0] MODE_DISP = 3'h5;
    localparam logic [2:0] MODE_INDEX = 3'h6;
    localparam logic [2:0] MODE_SPECIAL = 3'h7;

    localparam logic [2:0] SPEC_ABS_SHORT = 3'h0;
    localparam logic [2:0] SPEC_ABS_LONG = 3'h1;
    localparam logic [2:0] SPEC_PC_DISP = 3'h2;
    localparam logic [2:0] SPEC_PC_INDEX = 3'h3;
    localparam logic [2:0] SPEC_IMMEDIATE = 3'h4;

    // address register seven is the active system stack pointer
    localparam logic [2:0] STACK_REG = 3'h7;
    localparam logic DATA_BANK = 1'b0;
    localparam logic ADDR_BANK = 1'b1;

    localparam logic [2:0] STEP_BYTE = 3'h1;
    localparam logic [2:0] STEP_WORD = 3'h2;
    localparam logic [2:0] STEP_LONG = 3'h4;

    // index field of the brief extension word
    localparam int IDX_SEL_HI = 15;
    localparam int IDX_SEL_LO = 12;
    localparam int IDX_LONG_BIT = 11;

    typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} size_e;
    typedef enum logic [1:0] {KIND_REGISTER, KIND_MEMORY, KIND_IMMEDIATE,
        KIND_STATUS} kind_e;
    typedef enum logic [1:0] {REF_NONE, REF_DATA, REF_PROGRAM,
        REF_CONTROL} ref_e;

    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] regnum;
        size_e size;
        logic jump;
        logic status_target;
        logic condition_byte;
    } request_s;

    typedef struct packed {
        kind_e kind;
        ref_e ref_class;
        logic illegal;
        logic condition_byte;
        logic [ADDR_BITS-1:0] value;
    } result_s;

    typedef struct packed {
        logic en;
        logic [3:0] sel;
        logic [ADDR_BITS-1:0] data;
    } reg_write_s;

    function automatic logic [ADDR_BITS-1:0] sext16(
        input logic [EXT_BITS-1:0] w);
        return {{(ADDR_BITS-EXT_BITS){w[EXT_BITS-1]}}, w};
    endfunction
endpackage
`default_nettype wire

// File: ea_step.sv
// post-increment / pre-decrement step for a given operand size
// assumes the caller says whether the register is the stack pointer
`timescale 1ns/100ps
`default_nettype none
module ea_step
    import ea_pkg::*;
(
    input wire size_e i_size,
    input wire logic i_stack,
    output logic [ADDR_BITS-1:0] o_step
);
    logic [2:0] step;

    always_comb
    begin
        case (i_size)
            // a byte on the stack pointer moves two to stay word aligned
            SIZE_BYTE: step = i_stack ? STEP_WORD : STEP_BYTE;
            SIZE_WORD: step = STEP_WORD;
            SIZE_LONG: step = STEP_LONG;
            default: step = STEP_BYTE;
        endcase
        o_step = ADDR_BITS'(step);
    end
endmodule // ea_step
`default_nettype wire

// File: ea_sum.sv
// three-term address adder: base, signed displacement, index
// assumes index is already extended to full width by the caller
`timescale 1ns/100ps
`default_nettype none
module ea_sum
    import ea_pkg::*;
#(
    parameter int WIDTH = ADDR_BITS
)
(
    input wire logic [WIDTH-1:0] i_base,
    input wire logic [EXT_BITS-1:0] i_ext,
    input wire logic [WIDTH-1:0] i_index,
    input wire logic i_brief,
    input wire logic i_use_index,
    output logic [WIDTH-1:0] o_sum
);
    if (WIDTH < EXT_BITS)
    begin : g_width_check
        $error("ea_sum width below extension word width");
    end

    logic [WIDTH-1:0] disp;

    always_comb
    begin
        // brief form keeps only the low byte as displacement
        if (i_brief)
            disp = {{(WIDTH-BRIEF_BITS){i_ext[BRIEF_BITS-1]}},
                i_ext[BRIEF_BITS-1:0]};
        else
            disp = {{(WIDTH-EXT_BITS){i_ext[EXT_BITS-1]}}, i_ext};
        o_sum = i_base + disp + (i_use_index ? i_index : '0);
    end
endmodule // ea_sum
`default_nettype wire

// File: effective_address_unit.sv
// effective address decode and operand address generation
// assumes register file answers one cycle after a read strobe and
// the fetch unit answers o_ext_req with i_ext_valid plus word address
//
// How it works
// - specifier is a 3-bit mode plus a 3-bit register field
// - direct operands come from sixteen registers, data then address
// - mode 000: data register itself is the operand
// - mode 001: address register itself is the operand
// - mode 010: register holds address; data ref, control for jumps
// - mode 011: use register, then add 1, 2 or 4 by size
// - post-increment of stack pointer by a byte adds 2
// - mode 100: subtract 1, 2 or 4 first, then use as address
// - pre-decrement of stack pointer by a byte subtracts 2
// - mode 101: register plus sign-extended 16-bit extension word
// - mode 110: register plus sign-extended low byte plus index
// - mode 111: register field picks a special mode
// - 111/000: extension word sign-extended as absolute address
// - 111/001: two words, first is upper half
// - 111/010: program counter plus sign-extended word
// - 111/011: program counter plus low byte plus index
// - pc-relative uses extension word address; program reference
// - 111/100: immediate, one word or two for long
// - byte immediate is low byte, word immediate whole word
// - long immediate: first word upper, second lower
// - status register or its low byte may be the operand
// - address register seven counts as the stack pointer
`timescale 1ns/100ps
`default_nettype none
module effective_address_unit
    import ea_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire request_s i_request,
    output logic o_busy,
    output logic o_reg_rd_en,
    output logic [3:0] o_reg_rd_sel,
    input wire logic [ADDR_BITS-1:0] i_reg_rd_data,
    output logic o_ext_req,
    input wire logic i_ext_valid,
    input wire logic [EXT_BITS-1:0] i_ext_word,
    input wire logic [ADDR_BITS-1:0] i_program_counter,
    output logic o_done,
    output result_s o_result,
    output reg_write_s o_reg_wr
);
    typedef enum logic [2:0] {ST_IDLE, ST_BASE_ISSUE, ST_BASE_TAKE,
        ST_EXT_FIRST, ST_EXT_SECOND, ST_INDEX_ISSUE, ST_INDEX_TAKE,
        ST_FINISH} state_e;

    state_e state, next_state;
    request_s req, next_req;
    logic [ADDR_BITS-1:0] base, next_base;
    logic [ADDR_BITS-1:0] index, next_index;
    logic [ADDR_BITS-1:0] pc_at_ext, next_pc_at_ext;
    logic [EXT_BITS-1:0] ext_first, next_ext_first;
    logic [EXT_BITS-1:0] ext_second, next_ext_second;
    logic next_busy, next_reg_rd_en, next_ext_req, next_done;
    logic [3:0] next_reg_rd_sel;
    result_s next_result;
    reg_write_s next_reg_wr;
    logic [ADDR_BITS-1:0] step_value, sum_base, sum_value;
    logic sum_brief;

    function automatic logic is_special(input request_s r,
        input logic [2:0] s);
        return r.mode == MODE_SPECIAL && r.regnum == s;
    endfunction

    function automatic logic uses_index(input request_s r);
        return r.mode == MODE_INDEX || is_special(r, SPEC_PC_INDEX);
    endfunction

    function automatic logic wants_second(input request_s r);
        return is_special(r, SPEC_ABS_LONG) ||
            (is_special(r, SPEC_IMMEDIATE) && r.size == SIZE_LONG);
    endfunction

    function automatic logic special_illegal(input request_s r);
        return r.mode == MODE_SPECIAL && r.regnum > SPEC_IMMEDIATE;
    endfunction

    ea_step u_step (
        .i_size(req.size),
        .i_stack(req.regnum == STACK_REG),
        .o_step(step_value)
    );

    ea_sum #(.WIDTH(ADDR_BITS)) u_sum (
        .i_base(sum_base),
        .i_ext(ext_first),
        .i_index(index),
        .i_brief(sum_brief),
        .i_use_index(uses_index(req)),
        .o_sum(sum_value)
    );

    always_comb
    begin
        sum_brief = uses_index(req);
        if (req.mode != MODE_SPECIAL)
            sum_base = base;
        else if (req.regnum == SPEC_ABS_SHORT)
            sum_base = '0;
        else
            sum_base = pc_at_ext;
    end

    always_comb
    begin
        next_state = state;
        next_req = req;
        next_base = base;
        next_index = index;
        next_pc_at_ext = pc_at_ext;
        next_ext_first = ext_first;
        next_ext_second = ext_second;
        next_busy = o_busy;
        next_reg_rd_en = 1'b0;
        next_reg_rd_sel = o_reg_rd_sel;
        next_ext_req = o_ext_req;
        next_done = 1'b0;
        next_result = o_result;
        next_reg_wr = o_reg_wr;
        next_reg_wr.en = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (i_start)
                begin
                    next_req = i_request;
                    next_busy = 1'b1;
                    if (i_request.status_target ||
                        special_illegal(i_request))
                        next_state = ST_FINISH;
                    else if (i_request.mode != MODE_SPECIAL)
                    begin
                        next_reg_rd_en = 1'b1;
                        next_reg_rd_sel = {(i_request.mode == MODE_DATA_DIRECT)
                          ? DATA_BANK : ADDR_BANK, i_request.regnum};
                        next_state = ST_BASE_ISSUE;
                    end
                    else
                    begin
                        next_ext_req = 1'b1;
                        next_state = ST_EXT_FIRST;
                    end
                end
            end
            ST_BASE_ISSUE:
                next_state = ST_BASE_TAKE;
            ST_BASE_TAKE:
            begin
                next_base = i_reg_rd_data;
                if (req.mode == MODE_DISP || req.mode == MODE_INDEX)
                begin
                    next_ext_req = 1'b1;
                    next_state = ST_EXT_FIRST;
                end
                else
                    next_state = ST_FINISH;
            end
            ST_EXT_FIRST:
            begin
                if (i_ext_valid)
                begin
                    next_ext_first = i_ext_word;
                    next_pc_at_ext = i_program_counter;
                    if (wants_second(req))
                        next_state = ST_EXT_SECOND;
                    else if (uses_index(req))
                    begin
                        next_ext_req = 1'b0;
                        next_reg_rd_en = 1'b1;
                        next_reg_rd_sel = i_ext_word[IDX_SEL_HI:IDX_SEL_LO];
                        next_state = ST_INDEX_ISSUE;
                    end
                    else
                    begin
                        next_ext_req = 1'b0;
                        next_state = ST_FINISH;
                    end
                end
            end
            ST_EXT_SECOND:
            begin
                if (i_ext_valid)
                begin
                    next_ext_second = i_ext_word;
                    next_ext_req = 1'b0;
                    next_state = ST_FINISH;
                end
            end
            ST_INDEX_ISSUE:
                next_state = ST_INDEX_TAKE;
            ST_INDEX_TAKE:
            begin
                // word-sized index uses only its sign-extended low half
                next_index = ext_first[IDX_LONG_BIT] ? i_reg_rd_data
                    : sext16(i_reg_rd_data[EXT_BITS-1:0]);
                next_state = ST_FINISH;
            end
            ST_FINISH:
            begin
                next_done = 1'b1;
                next_busy = 1'b0;
                next_state = ST_IDLE;
                next_result.kind = KIND_MEMORY;
                next_result.ref_class = req.jump ? REF_CONTROL : REF_DATA;
                next_result.illegal = 1'b0;
                next_result.condition_byte = 1'b0;
                next_result.value = sum_value;
                next_reg_wr.sel = {ADDR_BANK, req.regnum};
                if (req.status_target)
                begin
                    next_result.kind = KIND_STATUS;
                    next_result.ref_class = REF_NONE;
                    next_result.condition_byte = req.condition_byte;
                    next_result.value = '0;
                end
                else
                begin
                    case (req.mode)
                        MODE_DATA_DIRECT, MODE_ADDR_DIRECT:
                        begin
                            next_result.kind = KIND_REGISTER;
                            next_result.ref_class = REF_NONE;
                            next_result.value = base;
                        end
                        MODE_INDIRECT:
                            next_result.value = base;
                        MODE_POSTINC:
                        begin
                            next_result.ref_class = REF_DATA;
                            next_result.value = base;
                            next_reg_wr.en = 1'b1;
                            next_reg_wr.data = base + step_value;
                        end
                        MODE_PREDEC:
                        begin
                            next_result.ref_class = REF_DATA;
                            next_result.value = base - step_value;
                            next_reg_wr.en = 1'b1;
                            next_reg_wr.data = base - step_value;
                        end
                        MODE_DISP, MODE_INDEX:
                            next_result.value = sum_value;
                        MODE_SPECIAL:
                        begin
                            case (req.regnum)
                                SPEC_ABS_SHORT:
                                    next_result.value = sum_value;
                                SPEC_ABS_LONG:
                                    next_result.value =
                                        {ext_first, ext_second};
                                SPEC_PC_DISP, SPEC_PC_INDEX:
                                    next_result.ref_class = REF_PROGRAM;
                                SPEC_IMMEDIATE:
                                begin
                                    next_result.kind = KIND_IMMEDIATE;
                                    next_result.ref_class = REF_NONE;
                                    case (req.size)
                                        SIZE_BYTE: next_result.value =
                                            {{(ADDR_BITS-BRIEF_BITS){1'b0}},
                                        ext_first[BRIEF_BITS-1:0]};
                                        SIZE_WORD: next_result.value =
                                            {{(ADDR_BITS-EXT_BITS){1'b0}},
                                            ext_first};
                                        default: next_result.value =
                                            {ext_first, ext_second};
                                    endcase
                                end
                                default:
                                begin
                                    next_result.illegal = 1'b1;
                                    next_result.ref_class = REF_NONE;
                                    next_result.value = '0;
                                end
                            endcase
                        end
                        default:
                            next_result.illegal = 1'b1;
                    endcase
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state <= ST_IDLE;
            req <= '0;
            base <= '0;
            index <= '0;
            pc_at_ext <= '0;
            ext_first <= '0;
            ext_second <= '0;
            o_busy <= 1'b0;
            o_reg_rd_en <= 1'b0;
            o_reg_rd_sel <= '0;
            o_ext_req <= 1'b0;
            o_done <= 1'b0;
            o_result <= '0;
            o_reg_wr <= '0;
        end
        else
        begin
            state <= next_state;
            req <= next_req;
            base <= next_base;
            index <= next_index;
            pc_at_ext <= next_pc_at_ext;
            ext_first <= next_ext_first;
            ext_second <= next_ext_second;
            o_busy <= next_busy;
            o_reg_rd_en <= next_reg_rd_en;
            o_reg_rd_sel <= next_reg_rd_sel;
            o_ext_req <= next_ext_req;
            o_done <= next_done;
            o_result <= next_result;
            o_reg_wr <= next_reg_wr;
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    logic fin_plain;
    assign fin_plain = o_done && !req.status_target;

    property p_illegal;
        fin_plain && special_illegal(req) |-> o_result.illegal && !o_reg_wr.en;
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("undefined special mode not flagged");

    property p_data_direct_latency;
        i_start && state == ST_IDLE && !i_request.status_target &&
        i_request.mode == MODE_DATA_DIRECT
        |-> ##1 o_reg_rd_en && o_reg_rd_sel[3] == DATA_BANK ##3
        o_done && o_result.kind == KIND_REGISTER;
    endproperty
    a_data_direct_latency: assert property (p_data_direct_latency)
        else $error("data register direct not answered in four cycles");

    property p_postinc;
        fin_plain && req.mode == MODE_POSTINC |-> o_reg_wr.en &&
        o_reg_wr.data == o_result.value + step_value && o_result.value == base;
    endproperty
    a_postinc: assert property (p_postinc)
        else $error("post-increment write-back wrong");

    property p_stack_byte;
        fin_plain && req.mode == MODE_POSTINC && req.regnum == STACK_REG &&
        req.size == SIZE_BYTE |->
        o_reg_wr.data - base == ADDR_BITS'(STEP_WORD);
    endproperty
    a_stack_byte: assert property (p_stack_byte)
        else $error("stack byte increment not two");

    property p_predec;
        fin_plain && req.mode == MODE_PREDEC |-> o_reg_wr.en &&
        o_reg_wr.data == o_result.value &&
        base - o_result.value == (req.size == SIZE_LONG ?
        ADDR_BITS'(STEP_LONG) : req.size == SIZE_WORD ||
        req.regnum == STACK_REG ? ADDR_BITS'(STEP_WORD) :
        ADDR_BITS'(STEP_BYTE));
    endproperty
    a_predec: assert property (p_predec)
        else $error("pre-decrement address wrong");

    property p_disp;
        fin_plain && req.mode == MODE_DISP |->
        o_result.value == base + sext16(ext_first);
    endproperty
    a_disp: assert property (p_disp)
        else $error("displacement address wrong");

    property p_pc_disp;
        fin_plain && is_special(req, SPEC_PC_DISP) |->
        o_result.ref_class == REF_PROGRAM &&
        o_result.value == pc_at_ext + sext16(ext_first);
    endproperty
    a_pc_disp: assert property (p_pc_disp)
        else $error("pc displacement wrong");

    property p_abs_long;
        fin_plain && is_special(req, SPEC_ABS_LONG) |->
        o_result.value == {ext_first, ext_second};
    endproperty
    a_abs_long: assert property (p_abs_long)
        else $error("absolute long order wrong");

    property p_one_word;
        state == ST_EXT_FIRST && i_ext_valid && !wants_second(req)
        |=> !o_ext_req ##1 !o_ext_req;
    endproperty
    a_one_word: assert property (p_one_word)
        else $error("extra extension word requested");

    c_postinc: cover property (fin_plain && req.mode == MODE_POSTINC);
    c_pc_index: cover property (fin_plain && is_special(req, SPEC_PC_INDEX));
    c_imm_long: cover property (fin_plain && is_special(req, SPEC_IMMEDIATE)
        && req.size == SIZE_LONG);
endmodule // effective_address_unit
`default_nettype wire

// File: ea_far_model.sv
// far side of the unit: register file and extension word fetch
// assumes the unit samples on the rising edge; this model drives at fall
`timescale 1ns/100ps
`default_nettype none
module ea_far_model
    import ea_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rd_en,
    input wire logic [3:0] i_rd_sel,
    input wire logic i_ext_req,
    input wire logic [15:0] i_first,
    input wire logic [15:0] i_second,
    input wire logic [3:0] i_delay,
    input wire logic [31:0] i_pc_base,
    output logic [31:0] o_rd_data,
    output logic o_ext_valid,
    output logic [15:0] o_ext_word,
    output logic [31:0] o_pc
);
    logic [31:0] regs [16];
    logic hold = 1'b0;
    logic idx = 1'b0;
    logic [3:0] cnt = 4'h0;
    initial {o_rd_data, o_ext_valid, o_ext_word, o_pc} = '0;
    // read data stands one cycle past the strobe, then is scrambled
    always @(negedge i_clock)
    begin
        if (i_rd_en) {o_rd_data, hold} <= {regs[i_rd_sel], 1'b1};
        else if (hold) hold <= 1'b0;
        else o_rd_data <= ~o_rd_data;
        if (o_ext_valid || !i_ext_req)
        begin
            {o_ext_valid, cnt} <= '0;
            {o_ext_word, o_pc} <= ~{o_ext_word, o_pc};
            if (!i_ext_req) idx <= 1'b0;
        end
        else if (cnt < i_delay) cnt <= cnt + 4'h1;
        else
        begin
            o_ext_valid <= 1'b1;
            o_ext_word <= idx ? i_second : i_first;
            o_pc <= i_pc_base + 32'({idx, 1'b0});
            idx <= 1'b1;
        end
    end
endmodule // ea_far_model
`default_nettype wire

// File: tb_top.sv
// random and corner operations on the effective address unit
// assumes the far side model serves register reads and extension words
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    bad_count++; $display("BAD %0t %h %h", $time, (a), (b)); end end
module tb_top
    import ea_pkg::*;
;
    logic i_clock = 0, i_resetn = 0, i_start = 0, o_busy, o_done;
    logic o_reg_rd_en, o_ext_req, ext_valid;
    logic [3:0] o_reg_rd_sel, dly = 4'h0;
    logic [15:0] ext_word, w0 = 16'h0000, w1 = 16'h0000;
    logic [31:0] rd_data, pc, pc_base = 32'h0000_0000, rv = 32'h0000_e95e;
    request_s i_request = '0, q;
    result_s o_result, e;
    reg_write_s o_reg_wr, ew;
    int bad_count = 0, tests_run = 0, n;
    initial forever #20 i_clock = ~i_clock;
    effective_address_unit u_dut (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_start(i_start), .i_request(i_request), .o_busy(o_busy),
        .o_reg_rd_en(o_reg_rd_en), .o_reg_rd_sel(o_reg_rd_sel),
        .i_reg_rd_data(rd_data), .o_ext_req(o_ext_req),
        .i_ext_valid(ext_valid), .i_ext_word(ext_word),
        .i_program_counter(pc), .o_done(o_done), .o_result(o_result),
        .o_reg_wr(o_reg_wr));
    ea_far_model u_far (.i_clock(i_clock), .i_rd_en(o_reg_rd_en),
        .i_rd_sel(o_reg_rd_sel), .i_ext_req(o_ext_req), .i_first(w0),
        .i_second(w1), .i_delay(dly), .i_pc_base(pc_base),
        .o_rd_data(rd_data), .o_ext_valid(ext_valid),
        .o_ext_word(ext_word), .o_pc(pc));
    function automatic logic [31:0] roll(input logic [31:0] v);
        for (int k = 0; k < 16; k++)
            v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        return v;
    endfunction
    function automatic logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction
    task automatic predict;
        logic [31:0] base, idx, st, b8;
        base = u_far.regs[{1'b1, q.regnum}];
        idx = u_far.regs[w0[15:12]];
        if (!w0[11]) idx = sx(idx[15:0]);
        b8 = sx({{8{w0[7]}}, w0[7:0]});
        // byte step on the stack pointer stays word aligned
        st = q.size == SIZE_LONG ? 32'h0000_0004 : (q.size == SIZE_WORD
            || q.regnum == STACK_REG) ? 32'h0000_0002 : 32'h0000_0001;
        e = '{KIND_MEMORY, q.jump ? REF_CONTROL : REF_DATA, 0, 0, base};
        ew = '0;
        case (q.mode)
            3'h0, 3'h1: e = '{KIND_REGISTER, REF_NONE, 0, 0,
                u_far.regs[{q.mode[0], q.regnum}]};
            3'h3: {e.ref_class, ew} = {REF_DATA, 2'b11, q.regnum, base + st};
            3'h4: {e.ref_class, e.value, ew} = {REF_DATA, base - st, 2'b11,
                q.regnum, base - st};
            3'h5: e.value = base + sx(w0);
            3'h6: e.value = base + b8 + idx;
            3'h7: case (q.regnum)
                3'h0: e.value = sx(w0);
                3'h1: e.value = {w0, w1};
                3'h2: {e.ref_class, e.value} = {REF_PROGRAM, pc_base + sx(w0)};
                3'h3: {e.ref_class, e.value} = {REF_PROGRAM,
                    pc_base + b8 + idx};
                3'h4: e = '{KIND_IMMEDIATE, REF_NONE, 0, 0, q.size == SIZE_BYTE
                    ? {24'h00_0000, w0[7:0]} : q.size == SIZE_WORD
                    ? {16'h0000, w0} : {w0, w1}};
                default: e.illegal = 1'b1;
            endcase
            default: ;
        endcase
        if (q.status_target) {e, ew} = {KIND_STATUS, REF_NONE, 1'b0,
            q.condition_byte, 32'h0000_0000, 37'h00_0000_0000};
    endtask
    task automatic conclude;
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #2_000_000 bad_count++;
        conclude;
    end
    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            rv = roll(rv);
            u_far.regs[i] = rv;
        end
        repeat (20) @(negedge i_clock);
        `CHK({o_busy, o_done, o_reg_rd_en, o_ext_req, o_reg_wr.en}, 5'h00)
        i_resetn = 1;
        for (int i = 0; i < 400; i++)
        begin
            rv = roll(rv);
            q = '{rv[2:0], rv[5:3], size_e'(rv[7:6] == 3 ? 0 : rv[7:6]),
                rv[8], rv[12:9] == 0, rv[13]};
            // corners: byte steps on the stack pointer, undefined selectors
            if (i < 5) q = '{3'(i < 2 ? 3 + i : 7), 3'(i < 2 ? 7 : 3 + i),
                SIZE_BYTE, 0, 0, 0};
            {w0, w1} = rv;
            rv = roll(rv);
            {dly, pc_base} = {rv[19:16], rv & 32'hffff_fffe};
            predict;
            {i_request, i_start} = {q, 1'b1};
            @(negedge i_clock);
            `CHK(o_busy, 1'b1)
            // a start held into the busy cycle must be ignored
            if (rv[24]) @(negedge i_clock);
            i_start = 0;
            n = 0;
            while (o_done !== 1'b1 && n < 80) @(negedge i_clock) n++;
            `CHK(o_done, 1'b1)
            `CHK(o_result.illegal, e.illegal)
            if (!e.illegal) `CHK(o_result.kind, e.kind)
            if (q.status_target) `CHK(o_result.condition_byte,
                e.condition_byte)
            if (!e.illegal) `CHK(o_result.ref_class, e.ref_class)
            if (!e.illegal) `CHK(o_result.value, e.value)
            `CHK(o_busy, 1'b0)
            `CHK({o_reg_rd_en, o_ext_req}, 2'b00)
            `CHK(o_reg_wr.en, ew.en)
            if (ew.en) `CHK(o_reg_wr, ew)
            $display("op %0d mode %0d done", i, q.mode);
        end
        conclude;
    end
endmodule // tb_top
`default_nettype wire
